//--- dv/fdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host on the byte port: signature, then pointer, then table
module fdp_host_model
   import fdp_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   start,
   input  wire logic                   slow,
   input  wire logic                   byte_valid,
   input  wire logic            [7:0]  byte_data,
   output var  fdp_pkg::fdp_byte_req_s byte_req,
   output logic                        done
);
   localparam logic [31:0] SIG = 32'h50444653; // Expected signature
   logic [4:0]  n;    // Bytes answered so far
   logic [23:0] ptr;  // Table start taken from the header
   logic        busy; // Walk in progress
   logic        pend; // Request out, answer awaited
   logic        hold; // Spare cycle after an answer
   logic [7:0]  nxt;  // Next address
   // Only the low pointer byte matters: the table sits below 100h
   always_comb begin
      if (n < 5'd4)
         nxt = 8'(n);
      else if (n < 5'd7)
         nxt = 8'(n) + 8'h08;
      else
         nxt = ptr[7:0] + 8'(n) - 8'h07;
   end
   // One request at a time; the address is scrambled when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_req <= '0;
         busy <= 1'b0;
         pend <= 1'b0;
         hold <= 1'b0;
         done <= 1'b0;
      end else begin
         byte_req.rd <= 1'b0;
         byte_req.addr <= ~byte_req.addr;
         hold <= 1'b0;
         if (start) begin
            busy <= 1'b1;
            n <= '0;
            done <= 1'b0;
         end else if (pend && byte_valid) begin
            pend <= 1'b0;
            hold <= 1'b1;
            n <= n + 5'd1;
            if (n >= 5'd4 && n < 5'd7)
               ptr[8*(n-4) +: 8] <= byte_data;
            // Give up at once on a foreign signature
            if ((n < 5'd4 && byte_data != SIG[8*n +: 8]) || n == 5'd22) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end else if (busy && !pend && !(slow && hold)) begin
            byte_req.rd <= 1'b1;
            byte_req.addr <= nxt;
            pend <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/fdp_param_rom_props.sv
`timescale 1ns/1ps
`default_nettype none
// Bus timing and table contents seen at the ports
module fdp_param_rom_props
   import fdp_pkg::*;
(
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire fdp_pkg::fdp_apb_req_s  apb_req,
   input wire logic            [31:0] prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire fdp_pkg::fdp_byte_req_s byte_req,
   input wire logic            [7:0]  byte_data,
   input wire logic                   byte_valid
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic       rd_ok; // A read completes this cycle
   logic [7:0] a;     // Address of the transfer
   assign rd_ok = pready && !apb_req.pwrite;
   assign a = apb_req.paddr;
   // One wait state, then a single-cycle answer
   a_ready_time: assert property (apb_req.psel && apb_req.penable
      && !$past(apb_req.penable) |-> !pready ##1 pready)
      else $error("answer not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_idle_quiet: assert property (!apb_req.psel |-> !pready)
      else $error("ready without a select");
   a_sig_word: assert property (
      rd_ok && a == 8'h00 |-> prdata == 32'h50444653)
      else $error("bad signature word");
   a_rev_word: assert property (
      rd_ok && a == 8'h04 |-> prdata == 32'hFF000106)
      else $error("bad revision word");
   a_hdr_word: assert property (
      rd_ok && a == 8'h08 |-> prdata == 32'h10010600)
      else $error("bad header word");
   a_ptr_word: assert property (
      rd_ok && a == 8'h0C |-> prdata == 32'hFF000030)
      else $error("bad pointer word");
   a_caps_word: assert property (
      rd_ok && a == 8'h30 |-> prdata == 32'hFFF920E5)
      else $error("bad capability word");
   a_size_word: assert property (
      rd_ok && a == 8'h34 |-> prdata == 32'h01FFFFFF)
      else $error("bad size word");
   a_quad_word: assert property (
      rd_ok && a == 8'h38 |-> prdata == 32'h6B08EB44)
      else $error("bad quad timing word");
   a_dual_word: assert property (
      rd_ok && a == 8'h3C |-> prdata == 32'hBB803B08)
      else $error("bad dual timing word");
   a_byte_answer: assert property (byte_req.rd |=> byte_valid)
      else $error("byte request not answered");
   a_byte_pulse: assert property (!byte_req.rd |=> !byte_valid)
      else $error("byte answer without request");
   a_unmapped_err: assert property (
      pready && a[7:6] == 2'b01 |-> pslverr && prdata == 32'h0)
      else $error("unmapped address not refused");
endmodule

bind fdp_param_rom fdp_param_rom_props chk_u (
   .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .byte_req(byte_req), .byte_data(byte_data), .byte_valid(byte_valid));
`default_nettype wire

//--- dv/fdp_param_rom_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the parameter table
module fdp_param_rom_tb_top;
   import fdp_pkg::*;
   logic          pclk, presetn, start, slow, done;
   fdp_apb_req_s  apb_req;
   fdp_byte_req_s byte_req;
   logic   [31:0] prdata;
   logic          pready, pslverr, byte_valid;
   logic   [7:0]  byte_data;
   int            mismatches, cmp_count, seed, i;
   logic   [33:0] qa[$]; // Data-checked flag, error, data
   logic   [7:0]  qb[$]; // Bytes the host should see
   logic   [31:0] pw;    // Expected probe lane, low byte used

   fdp_param_rom dut_u (.pclk(pclk), .presetn(presetn),
      .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .byte_req(byte_req),
      .byte_data(byte_data), .byte_valid(byte_valid));
   fdp_host_model host_u (.pclk(pclk), .presetn(presetn),
      .start(start), .slow(slow), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_req(byte_req), .done(done));

   // Clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Dword at a byte address; unmapped reads give zero
   function automatic logic [31:0] exp_word(input logic [7:0] a);
      case (a[7:2])
         6'h00: return 32'h50444653;
         6'h01: return 32'hFF000106;
         6'h02: return 32'h10010600;
         6'h03: return 32'hFF000030;
         6'h0C: return 32'hFFF920E5;
         6'h0D: return 32'h01FFFFFF;
         6'h0E: return 32'h6B08EB44;
         6'h0F: return 32'hBB803B08;
         default: return (a < 8'h40) ? 32'hFFFFFFFF : 32'h0;
      endcase
   endfunction

   // Byte of the k-th host request
   function automatic logic [7:0] exp_byte(input int k);
      logic [7:0]  a;
      logic [31:0] w;
      a = 8'((k < 4) ? k : (k < 7) ? k + 8 : k + 41);
      w = exp_word(a);
      return w[8*a[1:0] +: 8];
   endfunction

   task automatic cmp_apb(input logic [32:0] g, input logic [33:0] e);
      cmp_count++;
      if (g[32] !== e[32] || (e[33] && g[31:0] !== e[31:0])) begin
         mismatches++;
         $display("ERROR %0t: apb got %h exp %h", $time, g, e[32:0]);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t: byte got %h exp %h", $time, g, e);
      end
   endtask

   // Oldest note against each answer
   always @(posedge pclk) begin
      if (pready === 1'b1)
         cmp_apb({pslverr, prdata}, qa.pop_front());
      if (byte_valid === 1'b1)
         cmp_byte(byte_data, qb.pop_front());
   end

   // One transfer; psel stays up so the next may follow at once
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      qa.push_back({~w, e});
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      // Hold until pready is seen high at a rising edge; a hang is
      // left to the watchdog rather than to a local limit
      do @(posedge pclk); while (pready !== 1'b1);
   endtask

   task automatic idle(input int n);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask

   // Host walk of n answers; a shut port stops it after one
   task automatic host_run(input logic s, input int n);
      for (int k = 0; k < n; k++)
         qb.push_back((n == 1) ? 8'hFF : exp_byte(k));
      slow <= s;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      // Done is sampled at rising edges only
      do @(posedge pclk); while (done !== 1'b1);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      results();
   end

   // Main sequence
   initial begin
      seed = 67;
      mismatches = 0;
      cmp_count = 0;
      apb_req = '0;
      apb_req.pstrb = 4'hF;
      presetn = 1'b0;
      start = 1'b0;
      slow = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Whole table back to back, gap words too
      for (i = 0; i < 64; i += 4)
         apb(1'b0, 8'(i), '0, {1'b0, exp_word(8'(i))});
      // Random aligned reads, mapped and unmapped
      repeat (20) begin
         i = $random(seed) & 32'h7C;
         apb(1'b0, 8'(i), '0, {i >= 64, exp_word(8'(i))});
      end
      // Probe random bytes, inside the table and beyond it
      repeat (6) begin
         i = $random(seed) & 32'h7F;
         pw = (i < 64) ? exp_word(8'(i)) >> 8 * (i & 3) : 32'hFF;
         apb(1'b1, FDP_OFF_PROBE_ADR, 32'(i), {1'b0, 32'h0});
         apb(1'b0, FDP_OFF_PROBE_DAT, '0, {1'b0, 24'h0, pw[7:0]});
      end
      idle(1);
      $display("table read test done");
      // Misaligned read, then table writes lax and strict
      apb(1'b0, 8'h05, '0, {1'b1, 32'h0});
      apb(1'b1, 8'h00, '0, {1'b0, 32'h0});
      apb(1'b1, FDP_OFF_CTRL, 32'h3, {1'b0, 32'h0});
      apb(1'b1, 8'h30, '0, {1'b1, 32'h0});
      apb(1'b0, 8'h30, '0, {1'b0, 32'hFFF920E5});
      apb(1'b0, FDP_OFF_STATUS, '0, {1'b0, 32'h201});
      apb(1'b1, FDP_OFF_STATUS, 32'h3, {1'b0, 32'h0});
      apb(1'b1, FDP_OFF_CTRL, 32'h1, {1'b0, 32'h0});
      apb(1'b0, FDP_OFF_STATUS, '0, {1'b0, 32'h0});
      idle(2);
      $display("refusal test done");
      // Host walks prompt, then slow, then with the port shut
      host_run(1'b0, 23);
      host_run(1'b1, 23);
      apb(1'b1, FDP_OFF_CTRL, 32'h0, {1'b0, 32'h0});
      idle(1);
      host_run(1'b0, 1);
      apb(1'b0, FDP_OFF_STATUS, '0, {1'b0, 32'h002F0000});
      idle(2);
      $display("host walk test done");
      results();
   end
endmodule
`default_nettype wire

//--- src/fdp_param_rom.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Discoverable parameter table with an APB window and a byte port
module fdp_param_rom
   import fdp_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire fdp_pkg::fdp_apb_req_s apb_req,
   output logic               [31:0]  prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire fdp_pkg::fdp_byte_req_s byte_req,
   output logic               [7:0]   byte_data,
   output logic                       byte_valid
);
   import fdp_pkg::*;

   // Present and next state
   fdp_state_s st;
   fdp_state_s next_st;

   // Table lookup for bus reads
   logic [31:0] bus_word;
   // Table lookup for the serial byte port
   logic [31:0] byte_word;
   logic [7:0]  byte_rom;
   // Table lookup for the software probe
   logic [7:0]  probe_rom;
   logic [31:0] probe_word;

   // Decode helpers
   logic        setup;
   logic        in_table;
   logic        aligned;
   logic        known;
   logic        is_ro;
   logic [31:0] rd_val;
   logic        rd_err;
   logic        done;

   // Bus word lookup
   fdp_rom u_rom_bus (
      .word_idx (apb_req.paddr[5:2]),
      .lane     (2'h0),
      .word     (bus_word),
      .byte_out ()
   );

   // Serial byte lookup
   fdp_rom u_rom_byte (
      .word_idx (byte_req.addr[5:2]),
      .lane     (byte_req.addr[1:0]),
      .word     (byte_word),
      .byte_out (byte_rom)
   );

   // Probe lookup, steered by the software probe address
   fdp_rom u_rom_probe (
      .word_idx (st.probe_addr[5:2]),
      .lane     (st.probe_addr[1:0]),
      .word     (probe_word),
      .byte_out (probe_rom)
   );

   // Address classification for the current bus request
   always_comb begin
      setup    = apb_req.psel && !apb_req.penable;
      in_table = apb_req.paddr <= FDP_TABLE_LAST;
      aligned  = apb_req.paddr[1:0] == 2'h0;
      // Local registers share the table's word alignment
      known    = in_table ||
                 apb_req.paddr == FDP_OFF_CTRL ||
                 apb_req.paddr == FDP_OFF_PROBE_ADR ||
                 apb_req.paddr == FDP_OFF_PROBE_DAT ||
                 apb_req.paddr == FDP_OFF_STATUS;
      known    = known && aligned;
      // Read-only targets: the whole table and the probe data
      is_ro    = in_table || apb_req.paddr == FDP_OFF_PROBE_DAT;
      // Completion edge: pready is sampled high here
      done     = apb_req.psel && apb_req.penable && st.pready;
   end

   // Read data mux; unmapped words answer zero with an error
   always_comb begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      if (!known) begin
         // Misaligned or outside every register
         rd_err = 1'b1;
      end else if (in_table) begin
         // Table words, gaps read as all ones
         rd_val = bus_word;
      end else begin
         case (apb_req.paddr)
            FDP_OFF_CTRL: begin
               rd_val[1:0] = st.ctrl;
            end
            FDP_OFF_PROBE_ADR: begin
               rd_val[7:0] = st.probe_addr;
            end
            FDP_OFF_PROBE_DAT: begin
               // Beyond the table the probe sees erased fill
               rd_val[7:0] = (st.probe_addr <= FDP_TABLE_LAST) ?
                             probe_rom : FDP_FILL_BYTE;
            end
            FDP_OFF_STATUS: begin
               rd_val[FDP_STAT_ERR] = st.sticky_err;
               rd_val[FDP_STAT_REF_LSB +: 8] = st.refused;
               rd_val[FDP_STAT_RD_LSB +: 16] = st.byte_reads;
            end
            default: begin
               rd_err = 1'b1;
            end
         endcase
      end
   end

   // Next-state logic for the whole block
   always_comb begin
      next_st = st;
      // Byte port answer lasts one cycle
      next_st.byte_valid = 1'b0;

      // Serial byte port, one answer per request
      if (byte_req.rd) begin
         next_st.byte_valid = 1'b1;
         if (st.ctrl[FDP_CTRL_PORT_EN] &&
             byte_req.addr <= FDP_TABLE_LAST) begin
            // Signature and all fields straight from the table
            next_st.byte_data = byte_rom;
         end else begin
            // Disabled or beyond the modelled table: fill
            next_st.byte_data = FDP_FILL_BYTE;
         end
      end

      // Bus slave phases
      case (st.phase)
         FDP_PH_IDLE: begin
            // Wait for a setup cycle
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            if (setup) begin
               next_st.phase = FDP_PH_DECODE;
            end
         end
         FDP_PH_DECODE: begin
            // First access cycle: register the answer
            if (apb_req.psel && apb_req.penable) begin
               next_st.phase  = FDP_PH_ANSWER;
               next_st.pready = 1'b1;
               if (!apb_req.pwrite) begin
                  next_st.prdata  = rd_val;
                  next_st.pslverr = rd_err;
                  next_st.wr_ok   = 1'b0;
               end else if (!known) begin
                  // Unmapped write: error, no effect
                  next_st.prdata  = 32'h0;
                  next_st.pslverr = 1'b1;
                  next_st.wr_ok   = 1'b0;
               end else if (is_ro) begin
                  // Writes never alter the table
                  next_st.prdata  = 32'h0;
                  next_st.pslverr = st.ctrl[FDP_CTRL_STRICT];
                  next_st.wr_ok   = 1'b0;
               end else begin
                  next_st.prdata  = 32'h0;
                  next_st.pslverr = 1'b0;
                  next_st.wr_ok   = 1'b1;
               end
            end else begin
               // Master abandoned the transfer
               next_st.phase = FDP_PH_IDLE;
            end
         end
         FDP_PH_ANSWER: begin
            // Completion edge: writes take effect only here
            if (done) begin
               next_st.phase   = FDP_PH_IDLE;
               next_st.pready  = 1'b0;
               next_st.pslverr = 1'b0;
               if (apb_req.pwrite && st.wr_ok) begin
                  case (apb_req.paddr)
                     FDP_OFF_CTRL: begin
                        if (apb_req.pstrb[0]) begin
                           next_st.ctrl = apb_req.pwdata[1:0];
                        end
                     end
                     FDP_OFF_PROBE_ADR: begin
                        if (apb_req.pstrb[0]) begin
                           next_st.probe_addr = apb_req.pwdata[7:0];
                        end
                     end
                     FDP_OFF_STATUS: begin
                        // Write one to clear
                        if (apb_req.pstrb[0] &&
                            apb_req.pwdata[FDP_STAT_ERR]) begin
                           next_st.sticky_err = 1'b0;
                           next_st.refused    = 8'h0;
                        end
                        if (apb_req.pstrb[0] &&
                            apb_req.pwdata[FDP_STAT_CLR_CNT]) begin
                           next_st.byte_reads = 16'h0;
                        end
                     end
                     default: begin
                        // No other writable target
                     end
                  endcase
               end else if (apb_req.pwrite && is_ro && known) begin
                  // Refused write to the table or the probe data is recorded
                  next_st.sticky_err = 1'b1;
                  if (st.refused != 8'hFF) begin
                     next_st.refused = st.refused + 8'h1;
                  end
               end
            end
         end
         default: begin
            next_st.phase  = FDP_PH_IDLE;
            next_st.pready = 1'b0;
         end
      endcase

      // Byte reads counted after any clear, so a read wins
      if (byte_req.rd && next_st.byte_reads != 16'hFFFF) begin
         next_st.byte_reads = next_st.byte_reads + 16'h1;
      end
   end

   // State register; the table itself holds no state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.phase      <= FDP_PH_IDLE;
         st.prdata     <= 32'h0;
         st.pready     <= 1'b0;
         st.pslverr    <= 1'b0;
         st.wr_ok      <= 1'b0;
         st.ctrl       <= FDP_CTRL_RST;
         st.probe_addr <= 8'h0;
         st.sticky_err <= 1'b0;
         st.refused    <= 8'h0;
         st.byte_reads <= 16'h0;
         st.byte_data  <= 8'h0;
         st.byte_valid <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign prdata     = st.prdata;
   assign pready     = st.pready;
   assign pslverr    = st.pslverr;
   assign byte_data  = st.byte_data;
   assign byte_valid = st.byte_valid;
endmodule
`default_nettype wire

//--- src/fdp_pkg.sv
package fdp_pkg;

   // Byte addresses of the table dwords
   localparam logic [7:0] FDP_OFF_SIGNATURE = 8'h00;
   localparam logic [7:0] FDP_OFF_REVISION  = 8'h04;
   localparam logic [7:0] FDP_OFF_HDR_ID    = 8'h08;
   localparam logic [7:0] FDP_OFF_HDR_PTR   = 8'h0C;
   localparam logic [7:0] FDP_OFF_ERASE     = 8'h30;
   localparam logic [7:0] FDP_OFF_SIZE      = 8'h34;
   localparam logic [7:0] FDP_OFF_QUAD      = 8'h38;
   localparam logic [7:0] FDP_OFF_DUAL      = 8'h3C;
   localparam logic [7:0] FDP_TABLE_LAST    = 8'h3F;
   // Local control and status registers
   localparam logic [7:0] FDP_OFF_CTRL      = 8'h80;
   localparam logic [7:0] FDP_OFF_PROBE_ADR = 8'h84;
   localparam logic [7:0] FDP_OFF_PROBE_DAT = 8'h88;
   localparam logic [7:0] FDP_OFF_STATUS    = 8'h8C;

   // Header bytes
   localparam logic [31:0] FDP_SIGNATURE = {8'h50, 8'h44, 8'h46, 8'h53};
   localparam logic [7:0]  FDP_REV_MINOR = 8'h06;
   localparam logic [7:0]  FDP_REV_MAJOR = 8'h01;
   localparam logic [7:0]  FDP_HDR_COUNT = 8'h00;
   localparam logic [7:0]  FDP_FILL_BYTE = 8'hFF;
   localparam logic [7:0]  FDP_ID_LSB    = 8'h00;
   localparam logic [7:0]  FDP_ID_MSB    = 8'hFF;
   localparam logic [7:0]  FDP_TBL_LEN   = 8'h10;
   localparam logic [23:0] FDP_TBL_PTR   = 24'h000030;

   // Basic table fields
   localparam logic [1:0]  FDP_ERASE_4K  = 2'h1;
   localparam logic [7:0]  FDP_OP_ERASE  = 8'h20;
   localparam logic [7:0]  FDP_RD_CAPS   = 8'hF9;
   localparam logic [31:0] FDP_SIZE_M1   = 32'h01FFFFFF;
   localparam logic [4:0]  FDP_W_144 = 5'h04;
   localparam logic [2:0]  FDP_M_144 = 3'h2;
   localparam logic [7:0]  FDP_OP_144 = 8'hEB;
   localparam logic [4:0]  FDP_W_114 = 5'h08;
   localparam logic [2:0]  FDP_M_114 = 3'h0;
   localparam logic [7:0]  FDP_OP_114 = 8'h6B;
   localparam logic [4:0]  FDP_W_112 = 5'h08;
   localparam logic [2:0]  FDP_M_112 = 3'h0;
   localparam logic [7:0]  FDP_OP_112 = 8'h3B;
   localparam logic [4:0]  FDP_W_122 = 5'h00;
   localparam logic [2:0]  FDP_M_122 = 3'h4;
   localparam logic [7:0]  FDP_OP_122 = 8'hBB;
   localparam logic [31:0] FDP_GAP_WORD = 32'hFFFFFFFF;

   // Whole table, one dword per entry, lowest byte in bits 7:0
   localparam logic [31:0] FDP_TABLE [16] = '{
      FDP_SIGNATURE,
      {FDP_FILL_BYTE, FDP_HDR_COUNT, FDP_REV_MAJOR, FDP_REV_MINOR},
      {FDP_TBL_LEN, FDP_REV_MAJOR, FDP_REV_MINOR, FDP_ID_LSB},
      {FDP_ID_MSB, FDP_TBL_PTR},
      FDP_GAP_WORD, FDP_GAP_WORD, FDP_GAP_WORD, FDP_GAP_WORD,
      FDP_GAP_WORD, FDP_GAP_WORD, FDP_GAP_WORD, FDP_GAP_WORD,
      {FDP_FILL_BYTE, FDP_RD_CAPS, FDP_OP_ERASE,
       3'h7, 1'b0, 1'b0, 1'b1, FDP_ERASE_4K},
      FDP_SIZE_M1,
      {FDP_OP_114, FDP_M_114, FDP_W_114,
       FDP_OP_144, FDP_M_144, FDP_W_144},
      {FDP_OP_122, FDP_M_122, FDP_W_122,
       FDP_OP_112, FDP_M_112, FDP_W_112}
   };

   // Control and status field layout
   localparam int unsigned FDP_CTRL_PORT_EN = 0;
   localparam int unsigned FDP_CTRL_STRICT  = 1;
   localparam logic [1:0]  FDP_CTRL_RST     = 2'h1;
   localparam int unsigned FDP_STAT_ERR     = 0;
   localparam int unsigned FDP_STAT_CLR_CNT = 1;
   localparam int unsigned FDP_STAT_REF_LSB = 8;
   localparam int unsigned FDP_STAT_RD_LSB  = 16;

   // APB request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } fdp_apb_req_s;

   // Byte request from the serial read engine
   typedef struct packed {
      logic       rd;
      logic [7:0] addr;
   } fdp_byte_req_s;

   // Bus slave phases
   typedef enum logic [1:0] {
      FDP_PH_IDLE,
      FDP_PH_DECODE,
      FDP_PH_ANSWER
   } fdp_phase_e;

   // Every flip-flop of the block
   typedef struct packed {
      fdp_phase_e  phase;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        wr_ok;
      logic [1:0]  ctrl;
      logic [7:0]  probe_addr;
      logic        sticky_err;
      logic [7:0]  refused;
      logic [15:0] byte_reads;
      logic [7:0]  byte_data;
      logic        byte_valid;
   } fdp_state_s;

endpackage

//--- src/fdp_rom.sv
`timescale 1ns/1ps
`default_nettype none
// Constant table lookup: a dword and one byte lane of it
module fdp_rom
   import fdp_pkg::*;
(
   input  wire logic [3:0] word_idx,
   input  wire logic [1:0] lane,
   output logic      [31:0] word,
   output logic      [7:0]  byte_out
);
   // Lanes of the selected dword
   logic [7:0] lanes [4];

   // Pure constant, no state, so no reset or write reaches it
   assign word = FDP_TABLE[word_idx];

   // Split the dword so lowest address sits in bits 7:0
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lanes[g] = word[8*g +: 8];
      end
   endgenerate

   // Pick the addressed byte
   assign byte_out = lanes[lane];
endmodule
`default_nettype wire
